// file: hw/flgp_pkg.sv
// package of constants for the fast local-bus gpio port
// assumes a 16-byte window of 32-bit words with byte lane selects
package flgp_pkg;
  // --------------------------------------------------------------
  // sizes
  // --------------------------------------------------------------
  localparam int FLGP_PORT_W = 16;
  localparam int FLGP_ADDR_W = 4;
  // --------------------------------------------------------------
  // register offsets (byte addresses within the window)
  // --------------------------------------------------------------
  localparam logic [3:0] FLGP_OFS_DIR = 4'h0;
  localparam logic [3:0] FLGP_OFS_DATA = 4'h2;
  localparam logic [3:0] FLGP_OFS_PSEL = 4'h4;
  localparam logic [3:0] FLGP_OFS_CLR = 4'h6;
  localparam logic [3:0] FLGP_OFS_DIR_ALIAS0 = 4'h8;
  localparam logic [3:0] FLGP_OFS_SET = 4'hA;
  localparam logic [3:0] FLGP_OFS_DIR_ALIAS1 = 4'hC;
  localparam logic [3:0] FLGP_OFS_TOGGLE = 4'hE;
  // --------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------
  localparam logic [15:0] FLGP_RST_DIR = 16'h0000;
  localparam logic [15:0] FLGP_RST_DATA = 16'h0000;
  localparam logic [15:0] FLGP_RST_PSEL = 16'h0000;
  // --------------------------------------------------------------
  // register selector
  // --------------------------------------------------------------
  typedef enum logic [2:0] {
    FLGP_R_DIR, FLGP_R_DATA, FLGP_R_PSEL, FLGP_R_CLR,
    FLGP_R_SET, FLGP_R_TOGGLE, FLGP_R_NONE
  } flgp_reg_e;
endpackage

// file: hw/flgp_wr_if.sv
// interface carrying one decoded halfword write between modules
// assumes a single clock shared by both ends
`timescale 1ns/1ps
interface flgp_wr_if;
  logic [7:0] sel;
  logic [15:0] wdata;
  logic [15:0] bmask;
  modport src (output sel, output wdata, output bmask);
  modport dst (input sel, input wdata, input bmask);
endinterface

// file: hw/flgp_lane.sv
// halfword lane decode: splits a 32-bit bus word into two halfwords
// assumes byte lane selects follow little-endian lane numbering
`timescale 1ns/1ps
module flgp_lane
  import flgp_pkg::*;
(
  // bus request
  input wire logic [FLGP_ADDR_W-1:0] addr_i,
  input wire logic [3:0] be_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  // decoded halfword writes
  flgp_wr_if.src lo_w,
  flgp_wr_if.src hi_w
);
  // ----------------------------------------------------------------
  // lane split
  // ----------------------------------------------------------------
  // word base picks one of four words; each holds two halfword slots, words two and three only one reg
  always_comb begin
    lo_w.sel = 8'h00;
    hi_w.sel = 8'h00;
    lo_w.wdata = wdata_i[15:0];
    hi_w.wdata = wdata_i[31:16];
    lo_w.bmask = {{8{be_i[1]}}, {8{be_i[0]}}}; // R13
    hi_w.bmask = {{8{be_i[3]}}, {8{be_i[2]}}};
    if (wr_i && (be_i[1:0] != 2'b00)) begin
      lo_w.sel[{addr_i[3:2], 1'b0}] = 1'b1;
    end
    if (wr_i && (be_i[3:2] != 2'b00)) begin
      hi_w.sel[{addr_i[3:2], 1'b1}] = 1'b1;
    end
  end
endmodule

// file: hw/flgp_top.sv
// fast local-bus gpio port: dir, data, pin select and bit masks
// assumes a two-stage pipelined local bus, one clock, 32-bit data
//
// Overview of operation
// R01: pin select bit 1 routes pin to this port, 0 leaves it elsewhere
// R02: pin select mask is readable and writable
// R03: pin select mask resets to all zeros
// R04: clear mask zero bits clear data bits
// R05: set mask one bits set data bits
// R06: toggle mask one bits invert data bits
// R07: mask addresses store nothing, reads return data register
// R08: single-cycle pipelined transfers, no wait states
// R09: after reset all sixteen pins disabled from fast port
// R10: software enables pins, then direction, then data
// R11: direction 1 output, 0 input; resets to zero
// R12: fixed write map; offsets 0x08 and 0x0C ignore writes
// R13: byte, halfword and word accesses accepted
// R14: inputs sampled in read data phase, outputs update in write phase
// R15: enabled output pins drive pad from data bit
`timescale 1ns/1ps
module flgp_top
  import flgp_pkg::*;
#(
  parameter int PORT_W = FLGP_PORT_W
) (
  // clock, reset, enable
  input wire logic REF_CLK_I,
  input wire logic RSTN_I,
  input wire logic CE_I,
  // local bus address phase
  input wire logic BUS_SEL_I,
  input wire logic BUS_WR_I,
  input wire logic [FLGP_ADDR_W-1:0] BUS_ADDR_I,
  input wire logic [3:0] BUS_BE_I,
  // local bus data phase
  input wire logic [31:0] BUS_WDATA_I,
  output logic [31:0] BUS_RDATA_O,
  output logic BUS_READY_O,
  // pads
  input wire logic [15:0] PAD_IN_I,
  output logic [15:0] PAD_OUT_O,
  output logic [15:0] PAD_OE_O,
  output logic [15:0] PIN_SELECT_O
);
  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (PORT_W != 16) begin : g_bad_width
    $error("port width must be 16");
  end

  // ----------------------------------------------------------------
  // pad input synchroniser
  // ----------------------------------------------------------------
  logic [15:0] pad_s1_q, pad_s2_q;
  // two flops; only the second stage is looked at
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      pad_s1_q <= 16'h0000;
      pad_s2_q <= 16'h0000;
    end else if (CE_I) begin
      pad_s1_q <= PAD_IN_I;
      pad_s2_q <= pad_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // address phase capture
  // ----------------------------------------------------------------
  logic ap_wr_q, ap_rd_q, ap_wr_d, ap_rd_d;
  logic [FLGP_ADDR_W-1:0] ap_addr_q, ap_addr_d;
  logic [3:0] ap_be_q, ap_be_d;
  // one pipeline stage; the data phase follows the next edge
  always_comb begin
    ap_wr_d = BUS_SEL_I & BUS_WR_I;
    ap_rd_d = BUS_SEL_I & ~BUS_WR_I;
    ap_addr_d = BUS_ADDR_I;
    ap_be_d = BUS_BE_I;
  end
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      ap_wr_q <= 1'b0;
      ap_rd_q <= 1'b0;
      ap_addr_q <= 4'h0;
      ap_be_q <= 4'h0;
    end else if (CE_I) begin
      ap_wr_q <= ap_wr_d;
      ap_rd_q <= ap_rd_d;
      ap_addr_q <= ap_addr_d;
      ap_be_q <= ap_be_d;
    end
  end

  // ----------------------------------------------------------------
  // lane decode
  // ----------------------------------------------------------------
  flgp_wr_if lo_w();
  flgp_wr_if hi_w();
  flgp_lane u_lane (
    .addr_i(ap_addr_q),
    .be_i(ap_be_q),
    .wdata_i(BUS_WDATA_I),
    .wr_i(ap_wr_q),
    .lo_w(lo_w.src),
    .hi_w(hi_w.src)
  );

  // halfword index to register role; 0x08 and 0x0C hit no storage
  function automatic flgp_reg_e role_of(input logic [2:0] idx);
    case (idx)
      FLGP_OFS_DIR[3:1]: role_of = FLGP_R_DIR;
      FLGP_OFS_DATA[3:1]: role_of = FLGP_R_DATA;
      FLGP_OFS_PSEL[3:1]: role_of = FLGP_R_PSEL;
      FLGP_OFS_CLR[3:1]: role_of = FLGP_R_CLR;
      FLGP_OFS_SET[3:1]: role_of = FLGP_R_SET;
      FLGP_OFS_TOGGLE[3:1]: role_of = FLGP_R_TOGGLE;
      default: role_of = FLGP_R_NONE; // R12
    endcase
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [15:0] dir_q, dir_d, data_q, data_d, psel_q, psel_d;
  logic [15:0] hw_wd, hw_bm;
  flgp_reg_e hw_role;
  // write phase updates; byte lanes merge, masks act only on lanes hit
  always_comb begin
    dir_d = dir_q;
    data_d = data_q;
    psel_d = psel_q;
    hw_wd = 16'h0000;
    hw_bm = 16'h0000;
    hw_role = FLGP_R_NONE;
    for (int i = 0; i < 8; i++) begin
      hw_role = role_of(3'(i));
      hw_wd = i[0] ? hi_w.wdata : lo_w.wdata;
      hw_bm = i[0] ? hi_w.bmask : lo_w.bmask;
      if ((i[0] ? hi_w.sel[i] : lo_w.sel[i]) == 1'b1) begin
        case (hw_role)
          FLGP_R_DIR: dir_d = (dir_d & ~hw_bm) | (hw_wd & hw_bm); // R11
          FLGP_R_DATA: data_d = (data_d & ~hw_bm) | (hw_wd & hw_bm);
          FLGP_R_PSEL: psel_d = (psel_d & ~hw_bm) | (hw_wd & hw_bm); // R02
          FLGP_R_CLR: data_d = data_d & ~(~hw_wd & hw_bm); // R04
          FLGP_R_SET: data_d = data_d | (hw_wd & hw_bm); // R05
          FLGP_R_TOGGLE: data_d = data_d ^ (hw_wd & hw_bm); // R06
          default: data_d = data_d;
        endcase
      end
    end
  end
  // reset clears all three; no pin belongs to the port after reset
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      dir_q <= FLGP_RST_DIR;
      data_q <= FLGP_RST_DATA;
      psel_q <= FLGP_RST_PSEL; // R03 R09
    end else if (CE_I) begin
      dir_q <= dir_d;
      data_q <= data_d; // R14
      psel_q <= psel_d;
    end
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  logic [15:0] data_view;
  logic [31:0] rdata_d;
  // input pins show the synchronised pad; outputs show the data bit
  always_comb begin
    data_view = (data_q & dir_q) | (pad_s2_q & ~dir_q); // R14
    case (ap_addr_q[3:2])
      2'h0: rdata_d = {data_view, dir_q};
      2'h1: rdata_d = {data_view, psel_q}; // R02 R07
      2'h2: rdata_d = {data_view, dir_q}; // R07
      default: rdata_d = {data_view, dir_q}; // R07
    endcase
    if (!ap_rd_q) begin
      rdata_d = 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  logic [15:0] pad_out_d, pad_oe_d;
  // drive pad only when selected and an output
  always_comb begin
    pad_oe_d = psel_d & dir_d; // R01 R15
    pad_out_d = data_d & pad_oe_d; // R15
  end
  // registered so the pads change at the write data phase edge
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      BUS_RDATA_O <= 32'h0000_0000;
      BUS_READY_O <= 1'b0;
      PAD_OUT_O <= 16'h0000;
      PAD_OE_O <= 16'h0000;
      PIN_SELECT_O <= 16'h0000;
    end else if (CE_I) begin
      BUS_RDATA_O <= rdata_d;
      BUS_READY_O <= ap_rd_q | ap_wr_q; // R08
      PAD_OUT_O <= pad_out_d;
      PAD_OE_O <= pad_oe_d;
      PIN_SELECT_O <= psel_d; // R01
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);

  sequence s_req;
    CE_I && BUS_SEL_I;
  endsequence
  sequence s_done;
    CE_I ##1 (CE_I && BUS_READY_O);
  endsequence

  AST_ZERO_WAIT: assert property (s_req |=> s_done) // R08
    else $error("transfer not answered in the data phase");
  AST_PSEL_RESET: assert property ($rose(RSTN_I) |-> PIN_SELECT_O == 16'h0000) // R03
    else $error("pin select not zero after reset");
  AST_NO_PIN_RESET: assert property ($rose(RSTN_I) |-> PAD_OE_O == 16'h0000) // R09
    else $error("a pin is driven after reset");
  AST_OE_RULE: assert property (CE_I |=> PAD_OE_O == ($past(psel_d) & $past(dir_d))) // R15
    else $error("pad enable does not follow select and direction");
  AST_PSEL_OUT: assert property (CE_I |=> PIN_SELECT_O == psel_q) // R01
    else $error("pin select output differs from mask");
  // every mask sits in a high half, so the low half of the word never touches data
  AST_CLR: assert property (CE_I && hi_w.sel[3] && hi_w.bmask == 16'hFFFF // R04
      |=> data_q == ($past(data_q) & $past(hi_w.wdata)))
    else $error("clear mask wrong");
  AST_SET: assert property (CE_I && hi_w.sel[5] && hi_w.bmask == 16'hFFFF // R05
      |=> data_q == ($past(data_q) | $past(hi_w.wdata)))
    else $error("set mask wrong");
  AST_TOGGLE: assert property (CE_I && hi_w.sel[7] && hi_w.bmask == 16'hFFFF // R06
      |=> data_q == ($past(data_q) ^ $past(hi_w.wdata)))
    else $error("toggle mask wrong");
  AST_NOP_ALIAS: assert property (CE_I && ap_wr_q && ap_addr_q[3] == 1'b1 // R12
      |=> $stable(dir_q) && $stable(psel_q))
    else $error("write to spare offset changed state");
  AST_MASK_READ: assert property (CE_I && ap_rd_q && ap_addr_q[3:2] == 2'h3 // R07
      |=> BUS_RDATA_O[31:16] == $past(data_view))
    else $error("mask address read did not return data");

  // a write is taken in one address phase and answered with no read data
  sequence s_wr_taken;
    CE_I && BUS_SEL_I && BUS_WR_I;
  endsequence
  sequence s_wr_answered;
    CE_I ##1 (CE_I && BUS_READY_O && BUS_RDATA_O == 32'h0000_0000);
  endsequence
  // a read is taken in one address phase and answered one edge later
  sequence s_rd_taken;
    CE_I && BUS_SEL_I && !BUS_WR_I;
  endsequence
  sequence s_rd_answered;
    CE_I ##1 (CE_I && BUS_READY_O);
  endsequence

  AST_WRITE_ANSWER: assert property (s_wr_taken |=> s_wr_answered) // R08
    else $error("write not answered cleanly in its data phase");
  AST_READ_ANSWER: assert property (s_rd_taken |=> s_rd_answered) // R08
    else $error("read not answered in its data phase");
  // ready and read data only ever answer a transfer taken just before
  AST_NO_STRAY_READY: assert property (CE_I && !ap_rd_q && !ap_wr_q |=> !BUS_READY_O) // R08
    else $error("ready raised without a transfer");
  AST_RDATA_IDLE: assert property (CE_I && !ap_rd_q |=> BUS_RDATA_O == 32'h0000_0000) // R08
    else $error("read data not cleared outside a read");

  // whole-halfword writes land as written; byte merging is left to the bench
  AST_DIR_WRITE: assert property (CE_I && lo_w.sel[0] && lo_w.bmask == 16'hFFFF // R11
      |=> dir_q == $past(lo_w.wdata))
    else $error("direction write did not land");
  AST_PSEL_WRITE: assert property (CE_I && lo_w.sel[2] && lo_w.bmask == 16'hFFFF // R02
      |=> psel_q == $past(lo_w.wdata))
    else $error("pin select write did not land");
  AST_DATA_WRITE: assert property (CE_I && hi_w.sel[1] && hi_w.bmask == 16'hFFFF // R14
      |=> data_q == $past(hi_w.wdata))
    else $error("data write did not land");

  // nothing but a write to its own halfword may move select or direction
  AST_PSEL_HELD: assert property (CE_I && !lo_w.sel[2] |=> $stable(psel_q)) // R09
    else $error("pin select moved without a write");
  AST_DIR_HELD: assert property (CE_I && !lo_w.sel[0] |=> $stable(dir_q)) // R11
    else $error("direction moved without a write");

  // read map: select in word one, direction elsewhere, data view above
  AST_PSEL_READ: assert property (CE_I && ap_rd_q && ap_addr_q[3:2] == 2'h1 // R02
      |=> BUS_RDATA_O[15:0] == $past(psel_q))
    else $error("pin select read back wrong");
  AST_DIR_READ: assert property (CE_I && ap_rd_q && ap_addr_q[3:2] != 2'h1 // R11
      |=> BUS_RDATA_O[15:0] == $past(dir_q))
    else $error("direction read back wrong");
  AST_OUT_VIEW: assert property (CE_I && ap_rd_q // R14
      |=> (BUS_RDATA_O[31:16] & $past(dir_q)) == ($past(data_q) & $past(dir_q)))
    else $error("output pin did not read back its data bit");

  // pads always agree with the architectural registers
  AST_PAD_DRIVE: assert property (CE_I |=> PAD_OUT_O == (data_q & PAD_OE_O)) // R15
    else $error("pad drive does not follow the data bit");
  // a low enable holds every flop, bus answer and pad alike
  AST_FROZEN: assert property (!CE_I |=> $stable(BUS_READY_O) && $stable(PAD_OE_O)
      && $stable(PAD_OUT_O) && $stable(data_q) && $stable(psel_q))
    else $error("state moved while the clock enable was low");
endmodule

// file: dv/flgp_cpu_model.sv
// processor side of the local pipelined bus: one transfer per call
// assumes the port answers with a one-cycle ready a few edges later
`timescale 1ns/1ps
module flgp_cpu_model (
  // clock
  input wire logic clk_i,
  // answer from the port
  input wire logic [31:0] rdata_i,
  input wire logic ready_i,
  // address and data phase
  output logic sel_o,
  output logic wr_o,
  output logic [3:0] addr_o,
  output logic [3:0] be_o,
  output logic [31:0] wdata_o
);
  // --------------------------------------------------------------
  // bus transfer
  // --------------------------------------------------------------
  initial begin
    sel_o = 1'b0;
    wr_o = 1'b0;
    addr_o = 4'h0;
    be_o = 4'h0;
    wdata_o = 32'h0000_0000;
  end

  // select stands one cycle, data follows in the next cycle
  task automatic xfer(input logic w, input logic [3:0] a, input logic [3:0] b,
                      input logic [31:0] d, output logic [31:0] r, output logic ok);
    int n;
    @(posedge clk_i);
    sel_o <= 1'b1;
    wr_o <= w;
    addr_o <= a;
    be_o <= b;
    @(posedge clk_i);
    sel_o <= 1'b0;
    wdata_o <= d;
    n = 0;
    ok = 1'b0;
    // no wait states expected, so a short bound is enough
    while (!ok && n < 6) begin
      @(posedge clk_i);
      n++;
      ok = (ready_i === 1'b1);
    end
    r = rdata_i;
    // released data lines show the inverse, not a stale copy
    wdata_o <= ~d;
  endtask
endmodule

// file: dv/test_fast_local_bus_gpio_port.sv
// self-checking bench for the fast gpio port on the local bus
// assumes the cpu model drives the bus and pads are driven here
`timescale 1ns/1ps
module test_fast_local_bus_gpio_port
  import flgp_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic [15:0] pad_in = 16'h3C3C;
  logic sel, wr;
  logic [3:0] addr, be;
  logic [31:0] wdata, rdata;
  logic ready;
  logic [15:0] pad_out, pad_oe, pin_sel;
  logic [15:0] dir_m = 16'h0000;
  logic [15:0] dat_m = 16'h0000;
  logic [15:0] psel_m = 16'h0000;
  int miscompares = 0;
  int n_tests = 0;

  // --------------------------------------------------------------
  // clock, parts
  // --------------------------------------------------------------
  always #2 ref_clk = ~ref_clk;

  flgp_cpu_model i_cpu (.clk_i(ref_clk), .rdata_i(rdata), .ready_i(ready), .sel_o(sel),
    .wr_o(wr), .addr_o(addr), .be_o(be), .wdata_o(wdata));

  flgp_top #(.PORT_W(16)) i_dut (.REF_CLK_I(ref_clk), .RSTN_I(rstn), .CE_I(ce),
    .BUS_SEL_I(sel), .BUS_WR_I(wr), .BUS_ADDR_I(addr), .BUS_BE_I(be), .BUS_WDATA_I(wdata),
    .BUS_RDATA_O(rdata), .BUS_READY_O(ready), .PAD_IN_I(pad_in), .PAD_OUT_O(pad_out),
    .PAD_OE_O(pad_oe), .PIN_SELECT_O(pin_sel));

  // --------------------------------------------------------------
  // checks and tasks
  // --------------------------------------------------------------
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // input pins read the pad, output pins read back the data bit
  function automatic logic [15:0] view();
    return (dat_m & dir_m) | (pad_in & ~dir_m);
  endfunction

  // read a word, then compare the pad side with the model
  task automatic rd(input logic [3:0] a);
    logic [31:0] r;
    logic ok;
    i_cpu.xfer(1'b0, a, 4'hF, 32'h0000_0000, r, ok);
    chk("read ready", 32'h1, {31'h0, ok});
    chk("read word", {view(), (a[3:2] == 2'h1) ? psel_m : dir_m}, r);
    chk("pin select", {16'h0, psel_m}, {16'h0, pin_sel});
    chk("pad enable", {16'h0, psel_m & dir_m}, {16'h0, pad_oe});
    chk("pad drive", {16'h0, dat_m & psel_m & dir_m}, {16'h0, pad_out});
  endtask

  // write a word, apply both halves to the model, read it back
  task automatic step(input logic [3:0] a, input logic [3:0] b, input logic [31:0] d);
    logic [31:0] r;
    logic ok;
    logic [15:0] w, bm;
    i_cpu.xfer(1'b1, a, b, d, r, ok);
    chk("write ready", 32'h1, {31'h0, ok});
    for (int h = 0; h < 2; h++) begin
      w = d[16*h +: 16];
      bm = {{8{b[2*h+1]}}, {8{b[2*h]}}};
      case ({a[3:2], h[0], 1'b0})
        FLGP_OFS_DIR: dir_m = (dir_m & ~bm) | (w & bm);
        FLGP_OFS_DATA: dat_m = (dat_m & ~bm) | (w & bm);
        FLGP_OFS_PSEL: psel_m = (psel_m & ~bm) | (w & bm);
        FLGP_OFS_CLR: dat_m = dat_m & (w | ~bm);
        FLGP_OFS_SET: dat_m = dat_m | (w & bm);
        FLGP_OFS_TOGGLE: dat_m = dat_m ^ (w & bm);
        default: ;
      endcase
    end
    rd(a);
  endtask

  // --------------------------------------------------------------
  // sequence
  // --------------------------------------------------------------
  initial begin
    logic [31:0] fr;
    logic fok;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(4'h0);
    rd(4'h4);
    step(4'h4, 4'h3, 32'h0000_00FF);
    step(4'h0, 4'hF, 32'hA5A5_0F0F);
    step(4'h4, 4'hC, 32'hFF0F_0000);
    step(4'h8, 4'hF, 32'h00F0_1234);
    step(4'hC, 4'hF, 32'h8001_FFFF);
    step(4'h0, 4'h1, 32'h0000_00AA);
    step(4'h4, 4'hF, 32'hFFFF_F0F0);
    // a frozen port must neither answer nor take a write
    ce <= 1'b0;
    i_cpu.xfer(1'b1, 4'h4, 4'hF, 32'h0000_FFFF, fr, fok);
    ce <= 1'b1;
    chk("frozen ready", 32'h0, {31'h0, fok});
    rd(4'h4);
    pad_in <= 16'hC3C3;
    // pads pass a two-stage synchroniser before they are readable
    repeat (4) @(posedge ref_clk);
    rd(4'h8);
    summarize();
  end

  // watchdog against a port that never answers
  initial begin
    #20000;
    miscompares++;
    summarize();
  end
endmodule
